// [hdl/wdslp_top.v]
// wdslp_top.v: watchdog timer and sleep/wake controller with apb registers
// assumes: apb master on pclk; core issues clear/sleep as one-cycle pulses
// Summary of operation
// - watchdog counts on its own rc tick
// - expiry when awake gives watchdog device reset
// - expiry while asleep wakes and continues
// - any expiry clears timeout flag bit four
// - config enable cleared disables watchdog forever
// - shared scaler assign and ratio from prescale
// - clear or sleep zero watchdog and postscaler
// - clear zeros scaler only when assigned, keeps its assignment
// - sleep clears watchdog, pd low, to high
// - pins hold pre-sleep drive state during sleep
// - wake on reset pin, expiry, enabled interrupt
// - pd set at power-up, cleared by sleep
// - only clockless peripheral sources may wake
// - clocked peripherals cannot interrupt while asleep
// - wake needs individual enable, not global
// - after wake run next, then vector if global
// - pending enabled interrupt makes sleep a no-op
// - interrupt during sleep entry completes sleep first
// - flags set regardless of any enable
`timescale 1ns/1ps
`include "wdslp_defs.vh"
module wdslp_top #(
    parameter WD_BASE_LEN = 18,
    parameter WAKE_MASK   = `WDSLP_SRC_WAKE_MASK,
    parameter IO_WIDTH    = 8,
    parameter CFG_WORD    = `WDSLP_CFGWORD_DEF
) (
    input  wire                     pclk,
    input  wire                     presetn,
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [17:0]              paddr,
    input  wire [31:0]              pwdata,
    output reg  [31:0]              prdata,
    output reg                      pready,
    output reg                      pslverr,
    input  wire                     external_reset_pin_n,
    input  wire [`WDSLP_NUM_SRC-1:0] irq_event,
    input  wire [IO_WIDTH-1:0]      io_out_core,
    input  wire [IO_WIDTH-1:0]      io_oe_n_core,
    output reg  [IO_WIDTH-1:0]      io_out,
    output reg  [IO_WIDTH-1:0]      io_oe_n,
    output reg                      device_reset,
    output reg                      asleep,
    output reg                      main_osc_enable,
    output reg                      resume_pulse,
    output reg                      vector_pulse,
    output reg  [12:0]              vector_addr
);
    // -----------------------------------------------------------------
    // state and registers
    // -----------------------------------------------------------------
    localparam ST_RUN   = 3'b001;
    localparam ST_SLEEP = 3'b010;
    localparam ST_NEXT  = 3'b100;

    reg  [2:0]                state;
    reg  [7:0]                timer_prescale_config;
    reg                       timeout_flag_n;
    reg                       powerdown_flag_n;
    reg                       global_irq_enable;
    reg  [`WDSLP_NUM_SRC-1:0] irq_enable;
    reg  [`WDSLP_NUM_SRC-1:0] irq_flag;
    reg  [WD_BASE_LEN-1:0]    watchdog_counter;
    reg  [7:0]                scaler;
    reg                       wd_rst_seen;
    reg                       wd_tick_d;
    wire                      rc_tick;
    wire                      ext_rst_sync;
    reg                       ext_rst_d;
    // pin held low must give one reset pulse, not one per cycle
    wire                      ext_rst_rise = ext_rst_sync & ~ext_rst_d;
    wire [`WDSLP_NUM_SRC-1:0] irq_sync;

    wire watchdog_enable_cfg = CFG_WORD[`WDSLP_CFG_WDEN];
    wire scaler_assign       = timer_prescale_config[`WDSLP_PRE_ASSIGN];
    wire [2:0] ratio         = timer_prescale_config[2:0];

    // -----------------------------------------------------------------
    // synchronisers and rc oscillator
    // -----------------------------------------------------------------
    wdslp_rcosc u_rc (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (rc_tick)
    );

    wdslp_sync u_rst (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (~external_reset_pin_n),
        .dout    (ext_rst_sync)
    );

    genvar gi;
    generate
        for (gi = 0; gi < `WDSLP_NUM_SRC; gi = gi + 1) begin : g_irq
            wdslp_sync u_s (
                .pclk    (pclk),
                .presetn (presetn),
                .din     (irq_event[gi]),
                .dout    (irq_sync[gi])
            );
        end
    endgenerate

    reg [`WDSLP_NUM_SRC-1:0] irq_sync_d;
    wire [`WDSLP_NUM_SRC-1:0] irq_rise = irq_sync & ~irq_sync_d;

    // -----------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------
    wire apb_acc   = psel && penable && pready;
    wire apb_wr    = apb_acc && pwrite;
    wire a_pre     = (paddr == `WDSLP_ADDR_PRESCALE);
    wire a_cfg     = (paddr == `WDSLP_ADDR_CFGWORD);
    wire a_st      = (paddr == `WDSLP_ADDR_STATUS);
    wire a_ctl     = (paddr == `WDSLP_ADDR_CONTROL);
    wire a_ien     = (paddr == `WDSLP_ADDR_IRQEN);
    wire a_iflg    = (paddr == `WDSLP_ADDR_IRQFLAG);
    wire a_io      = (paddr == `WDSLP_ADDR_IOHOLD);
    wire a_hit     = a_pre | a_cfg | a_st | a_ctl | a_ien | a_iflg | a_io;

    wire clr_instr   = apb_wr && a_ctl && pwdata[`WDSLP_CTL_WATCHDOG_CLEAR_INSTR] && (state == ST_RUN);
    wire sleep_instr = apb_wr && a_ctl && pwdata[`WDSLP_CTL_SLEEP] && (state == ST_RUN);

    // only clockless sources are heard while asleep
    wire [`WDSLP_NUM_SRC-1:0] src_live =
        (state == ST_SLEEP) ? (WAKE_MASK[`WDSLP_NUM_SRC-1:0]) : {`WDSLP_NUM_SRC{1'b1}};
    wire [`WDSLP_NUM_SRC-1:0] flag_set = irq_rise & src_live;
    wire pending  = |(irq_flag & irq_enable);
    wire sleep_ok = sleep_instr && !pending;

    // -----------------------------------------------------------------
    // watchdog and shared scaler
    // -----------------------------------------------------------------
    wire wd_clear = clr_instr | sleep_ok;
    // ratio 1:2^ratio when assigned; else the base counter alone
    wire scaler_done = !scaler_assign || (scaler == ((8'h01 << ratio) - 8'h01));
    wire wd_full     = &watchdog_counter;
    wire wd_expire   = watchdog_enable_cfg && rc_tick && wd_full && scaler_done;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_counter <= {WD_BASE_LEN{1'b0}};
            scaler           <= 8'h00;
        end else if (wd_clear || !watchdog_enable_cfg) begin
            watchdog_counter <= {WD_BASE_LEN{1'b0}};
            if (scaler_assign) begin
                scaler <= 8'h00;
            end
        end else if (rc_tick) begin
            watchdog_counter <= watchdog_counter + {{(WD_BASE_LEN-1){1'b0}}, 1'b1};
            if (wd_full && scaler_assign) begin
                scaler <= scaler_done ? 8'h00 : scaler + 8'h01;
            end
        end
    end

    // -----------------------------------------------------------------
    // registers, flags and sleep control
    // -----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                 <= ST_RUN;
            timer_prescale_config <= `WDSLP_PRESCALE_RST;
            timeout_flag_n        <= 1'b1;
            powerdown_flag_n      <= 1'b1;
            global_irq_enable     <= 1'b0;
            irq_enable            <= {`WDSLP_NUM_SRC{1'b0}};
            irq_flag              <= {`WDSLP_NUM_SRC{1'b0}};
            irq_sync_d            <= {`WDSLP_NUM_SRC{1'b0}};
            device_reset          <= 1'b0;
            asleep                <= 1'b0;
            main_osc_enable       <= 1'b1;
            resume_pulse          <= 1'b0;
            vector_pulse          <= 1'b0;
            vector_addr           <= 13'h0000;
            wd_rst_seen           <= 1'b0;
            wd_tick_d             <= 1'b0;
            ext_rst_d             <= 1'b0;
        end else begin
            irq_sync_d   <= irq_sync;
            ext_rst_d    <= ext_rst_sync;
            resume_pulse <= 1'b0;
            vector_pulse <= 1'b0;
            device_reset <= 1'b0;
            wd_tick_d    <= wd_expire;
            if (apb_wr && a_pre) begin
                timer_prescale_config <= pwdata[7:0];
            end
            if (apb_wr && a_ctl) begin
                global_irq_enable <= pwdata[`WDSLP_CTL_GIE];
            end
            if (apb_wr && a_ien) begin
                irq_enable <= pwdata[`WDSLP_NUM_SRC-1:0];
            end
            // write-one-to-clear; a new event in the same cycle wins
            if (apb_wr && a_iflg) begin
                irq_flag <= (irq_flag & ~pwdata[`WDSLP_NUM_SRC-1:0]) | flag_set;
            end else begin
                irq_flag <= irq_flag | flag_set;
            end
            if (wd_expire) begin
                timeout_flag_n <= 1'b0;
            end
            case (state)
                ST_RUN: begin
                    if (ext_rst_rise) begin
                        device_reset <= 1'b1;
                        timer_prescale_config <= `WDSLP_PRESCALE_RST;
                    end else if (wd_expire) begin
                        device_reset          <= 1'b1;
                        wd_rst_seen           <= 1'b1;
                        timer_prescale_config <= `WDSLP_PRESCALE_RST;
                    end else if (clr_instr) begin
                        timeout_flag_n   <= 1'b1;
                        powerdown_flag_n <= 1'b1;
                    end else if (sleep_ok) begin
                        timeout_flag_n   <= 1'b1;
                        powerdown_flag_n <= 1'b0;
                        main_osc_enable  <= 1'b0;
                        asleep           <= 1'b1;
                        state            <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    // a flag raised during entry is seen here, after entry effects
                    if (ext_rst_rise) begin
                        device_reset          <= 1'b1;
                        timer_prescale_config <= `WDSLP_PRESCALE_RST;
                        asleep                <= 1'b0;
                        main_osc_enable       <= 1'b1;
                        state                 <= ST_RUN;
                    end else if (wd_expire || pending) begin
                        asleep          <= 1'b0;
                        main_osc_enable <= 1'b1;
                        resume_pulse    <= 1'b1;
                        state           <= (pending && global_irq_enable) ? ST_NEXT : ST_RUN;
                    end
                end
                ST_NEXT: begin
                    // prefetched instruction runs first, then the vector
                    vector_pulse <= 1'b1;
                    vector_addr  <= `WDSLP_IRQ_VECTOR;
                    state        <= ST_RUN;
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // i/o hold: outputs freeze while asleep
    // -----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_out  <= {IO_WIDTH{1'b0}};
            io_oe_n <= {IO_WIDTH{1'b1}};
        end else if (!(asleep || (state == ST_RUN && sleep_ok))) begin
            io_out  <= io_out_core;
            io_oe_n <= io_oe_n_core;
        end
    end

    // -----------------------------------------------------------------
    // apb slave: one wait state, read data on the access edge
    // -----------------------------------------------------------------
    reg [31:0] next_prdata;
    always @* begin
        next_prdata = 32'h0000_0000;
        if (a_pre) next_prdata[7:0] = timer_prescale_config;
        if (a_cfg) next_prdata[7:0] = CFG_WORD[7:0];
        if (a_st) begin
            next_prdata[`WDSLP_ST_TO] = timeout_flag_n;
            next_prdata[`WDSLP_ST_PD] = powerdown_flag_n;
            next_prdata[0]            = wd_rst_seen;
        end
        if (a_ctl) next_prdata[`WDSLP_CTL_GIE] = global_irq_enable;
        if (a_ctl) next_prdata[`WDSLP_CTL_IOSTATE] = asleep;
        if (a_ien) next_prdata[`WDSLP_NUM_SRC-1:0] = irq_enable;
        if (a_iflg) next_prdata[`WDSLP_NUM_SRC-1:0] = irq_flag;
        if (a_io) next_prdata[IO_WIDTH-1:0] = io_out;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= !a_hit || (pwrite && a_cfg);
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule // wdslp_top

// [hdl/wdslp_defs.vh]
// wdslp_defs.vh: constants for the watchdog and sleep/wake controller
// assumes: included by bare name from the design files under hdl/
`ifndef WDSLP_DEFS_VH
`define WDSLP_DEFS_VH

// -----------------------------------------------------------------
// register offsets (printed offsets that are not multiples of four)
// -----------------------------------------------------------------
`define WDSLP_IDX_PRESCALE    16'h0081
`define WDSLP_IDX_CFGWORD     16'h2007
`define WDSLP_ADDR_PRESCALE   18'h00204
`define WDSLP_ADDR_CFGWORD    18'h0801c
`define WDSLP_ADDR_STATUS     18'h10000
`define WDSLP_ADDR_CONTROL    18'h10004
`define WDSLP_ADDR_IRQEN      18'h10008
`define WDSLP_ADDR_IRQFLAG    18'h1000c
`define WDSLP_ADDR_IOHOLD     18'h10010

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define WDSLP_PRE_ASSIGN      3
`define WDSLP_CFG_WDEN        2
`define WDSLP_ST_PD           3
`define WDSLP_ST_TO           4
`define WDSLP_CTL_WATCHDOG_CLEAR_INSTR      0
`define WDSLP_CTL_SLEEP       1
`define WDSLP_CTL_GIE         2
`define WDSLP_CTL_IOSTATE     3

// -----------------------------------------------------------------
// reset values and timing
// -----------------------------------------------------------------
`define WDSLP_PRESCALE_RST    8'hff
`define WDSLP_CFGWORD_DEF     8'hff
`define WDSLP_NUM_SRC         11
`define WDSLP_SRC_WAKE_MASK   11'h7ff
`define WDSLP_IRQ_VECTOR      13'h0004
`define WDSLP_RC_PERIOD_NS    1000
`define WDSLP_RC_HALF_CYC     ((`WDSLP_RC_PERIOD_NS / 25) / 2)

`endif

// [hdl/wdslp_sync.v]
// wdslp_sync.v: three-stage synchroniser with agreement filter
// assumes: input may change at any time relative to pclk
`timescale 1ns/1ps
module wdslp_sync (
    input  wire pclk,
    input  wire presetn,
    input  wire din,
    output reg  dout
);
    reg s1;
    reg s2;
    reg s3;

    // first stage feeds only the second
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule // wdslp_sync

// [hdl/wdslp_rcosc.v]
// wdslp_rcosc.v: model of the free-running watchdog rc oscillator
// assumes: pclk always runs; the tick stands in for one rc edge
`timescale 1ns/1ps
`include "wdslp_defs.vh"
module wdslp_rcosc #(
    parameter HALF_CYC = `WDSLP_RC_HALF_CYC
) (
    input  wire pclk,
    input  wire presetn,
    output reg  tick
);
    reg [15:0] cnt;

    // never gated by sleep: keeps ticking while the core clock is off
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt >= HALF_CYC[15:0] - 16'h0001) begin
            cnt  <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule // wdslp_rcosc

// [sim/wdslp_chk_asserts.sv]
// wdslp_chk_asserts.sv: port checker for the watchdog and sleep/wake controller
// assumes: bound to wdslp_top from the testbench top file; one clock domain
`timescale 1ns/1ps
`include "wdslp_defs.vh"
module wdslp_chk #(
    parameter IO_WIDTH = 8
) (
    input wire                pclk,
    input wire                presetn,
    input wire                psel,
    input wire                penable,
    input wire                pwrite,
    input wire [17:0]         paddr,
    input wire [31:0]         pwdata,
    input wire                pready,
    input wire                pslverr,
    input wire                external_reset_pin_n,
    input wire [IO_WIDTH-1:0] io_out,
    input wire [IO_WIDTH-1:0] io_oe_n,
    input wire                device_reset,
    input wire                asleep,
    input wire                main_osc_enable,
    input wire                resume_pulse,
    input wire                vector_pulse,
    input wire [12:0]         vector_addr
);
    localparam logic [12:0] VEC = `WDSLP_IRQ_VECTOR;
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completed write of the sleep bit in the control register
    wire sleep_wr = psel && penable && pready && pwrite && paddr == `WDSLP_ADDR_CONTROL && pwdata[1];

    chk_osc_sleep_off: assert property (asleep |-> !main_osc_enable)
        else $error("oscillator driver on while asleep");
    chk_io_hold_sleep: assert property (asleep && $past(asleep) |-> $stable(io_out) && $stable(io_oe_n))
        else $error("pin drive changed during sleep");
    chk_entry_by_instr: assert property ($rose(asleep) |-> $past(sleep_wr) || $past(sleep_wr, 2) || $past(sleep_wr, 3))
        else $error("sleep entered without a sleep request");
    chk_wake_has_cause: assert property ($fell(asleep) |-> ##[0:1] (resume_pulse || device_reset))
        else $error("left sleep without resume or reset");
    chk_no_reset_asleep: assert property (external_reset_pin_n [*6] ##0 (asleep && $past(asleep)) |-> !device_reset)
        else $error("device reset while asleep without reset pin");
    chk_vector_after_resume: assert property (vector_pulse |-> $past(resume_pulse))
        else $error("vector without preceding resume");
    chk_vector_addr_val: assert property (vector_pulse |-> ##[0:1] (vector_addr == VEC))
        else $error("wrong vector address");
    chk_reset_one_cycle: assert property (device_reset |=> !device_reset)
        else $error("device reset longer than one cycle");
    chk_ready_second_access: assert property (psel && $rose(penable) |=> pready)
        else $error("pready not in second access cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");

    cover property (device_reset);
    cover property (vector_pulse);
    cover property ($rose(asleep));
endmodule // wdslp_chk

// [sim/wdslp_core_model.sv]
// wdslp_core_model.sv: behavioural core issuing register accesses, clear and sleep
// assumes: apb slave on pclk; tasks are called from the testbench
`timescale 1ns/1ps
module wdslp_core_model (
    input  wire         pclk,
    input  wire         pready,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [17:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h00000;
        pwdata = 32'h00000000;
    end
    // ------------------------------------------------
    // one apb transfer, held until pready
    // ------------------------------------------------
    task automatic xfer(input logic wr, input logic [17:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // released bus shows no stale address or data
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // wdslp_core_model

// [sim/tb.sv]
// tb.sv: self-checking bench for the watchdog and sleep/wake controller
// assumes: design, checker and core model compiled first
`timescale 1ns/1ps
`include "wdslp_defs.vh"
module tb;
    localparam logic [17:0] A_PRE = `WDSLP_ADDR_PRESCALE, A_CFG = `WDSLP_ADDR_CFGWORD, A_ST = `WDSLP_ADDR_STATUS;
    localparam logic [17:0] A_CTL = `WDSLP_ADDR_CONTROL, A_IEN = `WDSLP_ADDR_IRQEN, A_IFL = `WDSLP_ADDR_IRQFLAG;
    localparam logic [17:0] A_IO = `WDSLP_ADDR_IOHOLD;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        pin_n = 1'b1;
    logic [10:0] irq = 11'h000;
    logic [7:0]  io_v = 8'h00;
    logic [7:0]  io_e = 8'hff;
    logic [31:0] seed = 32'h00000030;
    logic [31:0] v;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    int          error_cnt = 0;
    int          compares = 0;
    int          rst_cnt = 0, res_cnt = 0, vec_cnt = 0, rst2_cnt = 0;
    wire         psel, penable, pwrite, pready, pslverr, dev_rst, dev_rst2, asleep, osc_en, resume, vector;
    wire  [17:0] paddr;
    wire  [31:0] pwdata, prdata;
    wire  [12:0] vaddr;
    wire  [7:0]  io_out, io_oe_n;

    always #12.5 pclk = ~pclk;

    wdslp_core_model core_u (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    wdslp_top #(.WD_BASE_LEN(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_reset_pin_n(pin_n), .irq_event(irq), .io_out_core(io_v), .io_oe_n_core(io_e), .io_out(io_out),
        .io_oe_n(io_oe_n), .device_reset(dev_rst), .asleep(asleep), .main_osc_enable(osc_en),
        .resume_pulse(resume), .vector_pulse(vector), .vector_addr(vaddr));
    // twin with the watchdog fused off, fed the same bus
    wdslp_top #(.WD_BASE_LEN(4), .CFG_WORD(8'hfb)) dut_nowd_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .external_reset_pin_n(pin_n), .irq_event(irq), .io_out_core(io_v), .io_oe_n_core(io_e), .io_out(),
        .io_oe_n(), .device_reset(dev_rst2), .asleep(), .main_osc_enable(), .resume_pulse(), .vector_pulse(),
        .vector_addr());
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_ev(input int got, input int exp);
        compares++;
        if (got != exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [17:0] a, input logic [31:0] d, input logic err,
                       input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({err, e & m});
        msk_q.push_back({1'b1, m});
        core_u.xfer(w, a, d);
    endtask
    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 1'b0, 32'h0, 32'h0);
    endtask
    task automatic rd(input logic [17:0] a, input logic [31:0] e, input logic [31:0] m);
        acc(1'b0, a, 32'h0, 1'b0, e, m);
    endtask
    task automatic kick(input int k);
        irq[k] <= 1'b1;
        repeat (6) @(posedge pclk);
        irq[k] <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    task automatic wait_ev(input int n);
        for (int i = 0; i < 3000 && rst_cnt + res_cnt < n; i++) @(posedge pclk);
        if (rst_cnt + res_cnt < n) error_cnt++;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ------------------------------------------------
    // monitor and watchdog
    // ------------------------------------------------
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
            cmp_rd({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
        if (dev_rst === 1'b1) rst_cnt <= rst_cnt + 1;
        if (dev_rst2 === 1'b1) rst2_cnt <= rst2_cnt + 1;
        if (resume === 1'b1) res_cnt <= res_cnt + 1;
        if (vector === 1'b1) vec_cnt <= vec_cnt + 1;
    end
    initial begin
        #(25 * 40000);
        error_cnt++;
        print_verdict();
    end
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_PRE, 32'hff, 32'hff);
        rd(A_CFG, 32'hff, 32'hff);
        rd(A_ST, 32'h18, 32'h18);
        acc(1'b0, 18'h3fff0, 32'h0, 1'b1, 32'h0, 32'hffffffff);
        acc(1'b1, A_CFG, 32'h0, 1'b1, 32'h0, 32'h0);
        wr(A_PRE, 32'h08);
        repeat (4) begin
            wr(A_CTL, 32'h1);
            repeat (200) @(posedge pclk);
        end
        cmp_ev(rst_cnt, 0);
        rd(A_PRE, 32'h08, 32'hff);
        rd(A_ST, 32'h18, 32'h18);
        wait_ev(1);
        cmp_ev(rst_cnt, 1);
        cmp_ev(rst2_cnt, 0);
        rd(A_PRE, 32'hff, 32'hff);
        rd(A_ST, 32'h09, 32'h19);
        // watchdog wake from sleep with pins held
        wr(A_PRE, 32'h08);
        wr(A_IEN, 32'h0);
        v = rnd();
        io_v <= v[7:0];
        io_e <= v[15:8];
        repeat (3) @(posedge pclk);
        wr(A_CTL, 32'h2);
        repeat (2) @(posedge pclk);
        io_v <= ~v[7:0];
        io_e <= ~v[15:8];
        rd(A_CTL, 32'h8, 32'h8);
        rd(A_ST, 32'h10, 32'h18);
        rd(A_IO, {24'h0, v[7:0]}, 32'hff);
        wait_ev(2);
        cmp_ev(res_cnt, 1);
        rd(A_ST, 32'h00, 32'h18);
        // every source wakes; odd sources with global enable vector
        for (int k = 0; k < 11; k++) begin
            wr(A_IFL, 32'h7ff);
            wr(A_IEN, 32'h1 << k);
            wr(A_CTL, {29'h0, k[0], 2'b10});
            kick(k);
            wait_ev(3 + k);
            rd(A_IFL, 32'h1 << k, 32'h7ff);
            rd(A_ST, 32'h10, 32'h18);
        end
        cmp_ev(res_cnt, 12);
        cmp_ev(vec_cnt, 5);
        // pending enabled flag turns sleep into a no-op
        wr(A_IFL, 32'h7ff);
        wr(A_IEN, 32'h1);
        kick(0);
        wr(A_CTL, 32'h1);
        wr(A_CTL, 32'h2);
        repeat (3) @(posedge pclk);
        rd(A_CTL, 32'h0, 32'h8);
        rd(A_ST, 32'h18, 32'h18);
        wr(A_IFL, 32'h7ff);
        wr(A_IEN, 32'h0);
        kick(5);
        rd(A_IFL, 32'h20, 32'h7ff);
        wr(A_IFL, 32'h20);
        rd(A_IFL, 32'h0, 32'h7ff);
        // reset pin while asleep
        cmp_ev(rst2_cnt, 0);
        wr(A_CTL, 32'h2);
        repeat (4) @(posedge pclk);
        pin_n <= 1'b0;
        repeat (6) @(posedge pclk);
        pin_n <= 1'b1;
        repeat (6) @(posedge pclk);
        cmp_ev(rst_cnt, 2);
        cmp_ev(res_cnt, 12);
        print_verdict();
    end
endmodule // tb

bind wdslp_top wdslp_chk #(.IO_WIDTH(IO_WIDTH)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .external_reset_pin_n(external_reset_pin_n), .io_out(io_out), .io_oe_n(io_oe_n),
    .device_reset(device_reset), .asleep(asleep), .main_osc_enable(main_osc_enable),
    .resume_pulse(resume_pulse), .vector_pulse(vector_pulse), .vector_addr(vector_addr));
